/* File: logic/vic_interp_ctrl.sv */
/*
 * Interpolated oscillator control: APB register file (control, input
 * code, divider) and a first-order noise-shaping modulator producing a
 * one-bit control stream at module clock / divider.
 * Assumes pclk is the CPU clock; the module clock is derived internally
 * as a one-in-two enable, so a single clock domain is kept.
 */
// The address map and the APB register port were chosen for this implementation.
//
// Contract
// [R1] Precision codes 1 to 7 select 15 down to 9 bits.
// [R2] Precision code 0, the reset value, selects 16 bits.
// [R3] Run bit is writable at any time.
// [R4] Run bit clear holds modulator in reset, output low.
// [R5] Run bit clear: control and divider writes accepted harmlessly.
// [R6] One write may change fields and set run together.
// [R7] Run bit set: divider and control fields ignore writes.
// [R8] Write clearing run keeps other fields unchanged.
// [R9] Interpolation and output happen only while running.
// [R10] Input code writes take effect only while running.
// [R11] Below 16 bits, only the top bits of the code count.
// [R12] Code in bits 15-0; bits 31-16 read zero.
// [R13] Rate clock is module clock (pclk/2) over divider.
// [R14] Software picks divider as rounded module clock over rate.
// [R15] Divider zero acts as one.
// [R16] Divider resets to one, upper half reads zero.
// [R17] Software supplies codes as they become available.
// [R18] Software enables: clear run, precision, divider, set run.
// [R19] One-bit modulator average equals selected code fraction.
// [R20] New code applies at the next rate-clock boundary.
`timescale 1ns/1ps
`default_nettype none
module vic_interp_ctrl
    import vic_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire vic_pkg::vic_apb_req_t apb_req,
    output var  vic_pkg::vic_apb_rsp_t apb_rsp,
    output logic                   oscillator_control_out
);
    import vic_pkg::*;

    // Register state
    logic                    run_reg;
    logic [VIC_PREC_W-1:0]   prec_reg;
    logic [VIC_CODE_W-1:0]   input_code_field_reg;
    logic [VIC_CODE_W-1:0]   divider_field_reg;
    logic [31:0]             rdata_reg;

    // Modulator state
    vic_phase_t              phase_reg;
    logic [VIC_CODE_W-1:0]   div_cnt_reg;
    logic [VIC_CODE_W-1:0]   code_apply_reg;
    logic [VIC_CODE_W-1:0]   accum_reg;
    logic                    out_reg;

    // Decoded controls
    logic                    wr_en;
    logic                    rd_en;
    logic                    hit_control;
    logic                    hit_input;
    logic                    hit_divider;
    logic [VIC_CODE_W-1:0]   div_eff;
    logic [VIC_CODE_W-1:0]   code_mask;
    logic [VIC_CODE_W-1:0]   code_sel;
    logic [4:0]              prec_bits;
    logic                    module_tick;
    logic                    rate_tick;
    logic [VIC_CODE_W:0]     accum_next;

    // Bus decode; zero-wait slave, writes strobe in the access phase, reads in the setup phase
    assign wr_en       = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en       = apb_req.psel && !apb_req.penable
                         && !apb_req.pwrite;
    assign hit_control = (apb_req.paddr == VIC_OFF_CONTROL);
    assign hit_input   = (apb_req.paddr == VIC_OFF_INPUT);
    assign hit_divider = (apb_req.paddr == VIC_OFF_DIVIDER);

    // Answer in the first access cycle; unmapped addresses flag an error
    always_comb begin
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable
                          && !(hit_control || hit_input || hit_divider);
        apb_rsp.prdata  = rdata_reg;
    end

    // Run bit: writable whatever its current value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
        end else if (wr_en && hit_control) begin
            run_reg <= apb_req.pwdata[VIC_RUN_BIT]; // see [R3]
        end
    end

    // Precision field: locked while running, even by a stopping write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prec_reg <= VIC_PREC_RESET;
        end else if (wr_en && hit_control && !run_reg) begin
            // Taken along with a run-setting write; see [R5] see [R6]
            prec_reg <= apb_req.pwdata[VIC_PREC_MSB:VIC_PREC_LSB];
        end // Else held; see [R7] see [R8]
    end

    // Divider: writable only while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_field_reg <= VIC_DIV_RESET; // see [R16]
        end else if (wr_en && hit_divider && !run_reg) begin
            divider_field_reg <= apb_req.pwdata[VIC_CODE_W-1:0]; // see [R5]
        end // Running writes dropped; see [R7]
    end

    // Input code: accepted only while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_code_field_reg <= VIC_CODE_RESET;
        end else if (wr_en && hit_input && run_reg) begin
            // Upper half discarded; see [R10] see [R12]
            input_code_field_reg <= apb_req.pwdata[VIC_CODE_W-1:0];
        end
    end

    // Read data captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= VIC_ZERO_WORD;
        end else if (rd_en) begin
            rdata_reg <= VIC_ZERO_WORD;
            if (hit_control) begin
                rdata_reg[VIC_RUN_BIT]               <= run_reg;
                rdata_reg[VIC_PREC_MSB:VIC_PREC_LSB] <= prec_reg;
            end else if (hit_input) begin
                rdata_reg[VIC_CODE_W-1:0] <= input_code_field_reg; // see [R12]
            end else if (hit_divider) begin
                rdata_reg[VIC_CODE_W-1:0] <= divider_field_reg; // see [R16]
            end
        end
    end

    // Zero divider is illegal and behaves as one
    assign div_eff = (divider_field_reg == VIC_DIV_ILLEGAL) ?
                     VIC_DIV_SAFE : divider_field_reg; // see [R15]

    // Precision code to bit count: 0 is 16, then one fewer per step
    assign prec_bits = VIC_FULL_BITS - {2'b00, prec_reg}; // see [R1] see [R2]

    // Keep only the top prec_bits of the code
    assign code_mask = {VIC_CODE_W{1'b1}} << (VIC_FULL_BITS - prec_bits);
    assign code_sel  = input_code_field_reg & code_mask; // see [R11]

    // Module clock phase; a toggling enable instead of a derived clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= VIC_PH_LOW;
        end else if (!run_reg) begin
            phase_reg <= VIC_PH_LOW; // see [R4]
        end else begin
            phase_reg <= (phase_reg == VIC_PH_LOW) ? VIC_PH_HIGH : VIC_PH_LOW;
        end
    end
    assign module_tick = (phase_reg == VIC_PH_HIGH); // see [R13]

    // Rate divider counts module-clock ticks
    assign rate_tick = module_tick && (div_cnt_reg >= div_eff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= VIC_CNT_ONE;
        end else if (!run_reg) begin
            div_cnt_reg <= VIC_CNT_ONE; // see [R4]
        end else if (module_tick) begin
            // Wraps to one, giving exactly div_eff ticks per period
            div_cnt_reg <= rate_tick ? VIC_CNT_ONE
                                     : div_cnt_reg + VIC_CNT_ONE; // see [R13]
        end
    end

    // Code latched only on a rate boundary so a period never splits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_apply_reg <= VIC_CODE_RESET;
        end else if (!run_reg) begin
            code_apply_reg <= VIC_CODE_RESET; // see [R4]
        end else if (rate_tick) begin
            code_apply_reg <= code_sel; // see [R20]
        end
    end

    // First-order sigma-delta: carry out is the output bit
    // Carry lives only in accum_next; the register keeps the low word
    assign accum_next = {1'b0, accum_reg} + {1'b0, code_apply_reg};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_reg <= '0;
        end else if (!run_reg) begin
            accum_reg <= '0; // see [R4]
        end else if (rate_tick) begin
            accum_reg <= accum_next[VIC_CODE_W-1:0]; // see [R19]
        end
    end

    // Output bit registered; low from the cycle after run clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 1'b0;
        end else if (!run_reg) begin
            out_reg <= 1'b0; // see [R4]
        end else if (rate_tick) begin
            out_reg <= accum_next[VIC_CODE_W]; // see [R9] see [R19]
        end
    end
    assign oscillator_control_out = out_reg;

endmodule : vic_interp_ctrl
`default_nettype wire

/* File: pkg/vic_pkg.sv */
/*
 * Package for the interpolated oscillator control block: register map,
 * field layout, reset values, bus carrier structs and modulator states.
 * Assumes an APB slave with 32-bit data and one word per register.
 */
`default_nettype none
package vic_pkg;

    // Register byte offsets
    localparam logic [11:0] VIC_OFF_CONTROL   = 12'h000;
    localparam logic [11:0] VIC_OFF_INPUT     = 12'h004;
    localparam logic [11:0] VIC_OFF_DIVIDER   = 12'h008;
    localparam int          VIC_ADDR_W        = 12;

    // Control register layout
    localparam int VIC_RUN_BIT   = 0;
    localparam int VIC_PREC_LSB  = 1;
    localparam int VIC_PREC_MSB  = 3;
    localparam int VIC_PREC_W    = 3;

    // Field widths and reset values
    localparam int              VIC_CODE_W      = 16;
    localparam logic [2:0]      VIC_PREC_RESET  = 3'h0;
    localparam logic [15:0]     VIC_CODE_RESET  = 16'h0000;
    localparam logic [15:0]     VIC_DIV_RESET   = 16'h0001;
    localparam logic [15:0]     VIC_DIV_ILLEGAL = 16'h0000;
    localparam logic [15:0]     VIC_DIV_SAFE    = 16'h0001;
    localparam logic [15:0]     VIC_CNT_ONE     = 16'h0001;
    localparam logic [4:0]      VIC_FULL_BITS   = 5'h10;
    localparam logic [31:0]     VIC_ZERO_WORD   = 32'h0000_0000;

    // Module clock is the bus clock halved
    localparam int VIC_MODCLK_DIV = 2;

    // APB request carrier
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [VIC_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } vic_apb_req_t;

    // APB answer carrier
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } vic_apb_rsp_t;

    // Module-clock phase, Gray coded
    typedef enum logic [0:0] {
        VIC_PH_LOW  = 1'b0,
        VIC_PH_HIGH = 1'b1
    } vic_phase_t;

endpackage : vic_pkg
`default_nettype wire

/* File: verif/tb_vic_interp_ctrl.sv */
/* Bench for vic_interp_ctrl: APB master and output scenarios.
   Assumes vic_monitor is bound and the oscillator model is attached. */
`timescale 1ns/1ps
`default_nettype none
module tb_vic_interp_ctrl;
    import vic_pkg::*;
    logic         pclk, presetn, vout, meas_en;
    vic_apb_req_t req;
    vic_apb_rsp_t rsp;
    logic [15:0]  low_cnt, edge_cnt;
    logic [31:0]  rd, lo_n, ed_n;
    int           n_mismatch, tests_run;
    vic_interp_ctrl uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .oscillator_control_out(vout));
    vic_vcxo_model vcxo (.pclk(pclk), .ctrl_in(vout), .meas_en(meas_en),
        .low_cnt(low_cnt), .edge_cnt(edge_cnt));
    always #2 pclk = ~pclk;
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // Hold the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        if (n >= 64) n_mismatch++;
        if (n >= 64) finish_test();
        rd = rsp.prdata;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] lo,
                       input logic [31:0] hi);
        tests_run++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h..%h",
                     $time, g, lo, hi);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e, e);
    endtask : rchk
    // Window read at the falling edge, before the counts clear
    task automatic meas(input int cyc);
        meas_en <= 1'b1;
        repeat (cyc) @(posedge pclk);
        meas_en <= 1'b0;
        @(negedge pclk);
        lo_n = {16'h0, low_cnt};
        ed_n = {16'h0, edge_cnt};
        @(posedge pclk);
    endtask : meas
    task automatic t_run(input logic [2:0] p, input logic [15:0] dv,
                         input logic [15:0] c, input int cyc);
        apb(1'b1, VIC_OFF_CONTROL, {28'h0, p, 1'b0});
        apb(1'b1, VIC_OFF_DIVIDER, {16'h0, dv});
        apb(1'b1, VIC_OFF_CONTROL, {28'h0, p, 1'b1});
        apb(1'b1, VIC_OFF_INPUT, {16'h0, c});
        repeat (64) @(posedge pclk);
        meas(cyc);
    endtask : t_run
    task automatic t_lock();
        rchk(VIC_OFF_CONTROL, 32'h0);
        rchk(VIC_OFF_DIVIDER, 32'h1);
        rchk(12'h00C, 32'h0);
        apb(1'b1, VIC_OFF_INPUT, 32'h1234);
        rchk(VIC_OFF_INPUT, 32'h0);
        apb(1'b1, VIC_OFF_DIVIDER, 32'hFFFF_0005);
        rchk(VIC_OFF_DIVIDER, 32'h5);
        apb(1'b1, VIC_OFF_CONTROL, 32'hFFFF_FFF7);
        rchk(VIC_OFF_CONTROL, 32'h7);
        apb(1'b1, VIC_OFF_DIVIDER, 32'h9);
        apb(1'b1, VIC_OFF_CONTROL, 32'hB);
        rchk(VIC_OFF_DIVIDER, 32'h5);
        rchk(VIC_OFF_CONTROL, 32'h7);
        apb(1'b1, VIC_OFF_INPUT, 32'hFFFF_ABCD);
        rchk(VIC_OFF_INPUT, 32'hABCD);
        apb(1'b1, VIC_OFF_CONTROL, 32'hC);
        rchk(VIC_OFF_CONTROL, 32'h6);
    endtask : t_lock
    // Near-full code: dropped low bits set the number of low ticks
    task automatic t_duty();
        int e;
        for (int p = 0; p < 8; p++) begin
            t_run(p[2:0], 16'h1, 16'hFFFF, 4096);
            e = (2048 << p) >> 16;
            chk(lo_n, 2 * e - (e > 0), 2 * e + 2);
        end
    endtask : t_duty
    task automatic t_rate();
        t_run(3'h0, 16'h3, 16'h8000, 600);
        chk(ed_n, 99, 101);
        t_run(3'h0, 16'h0, 16'h8000, 600);
        chk(ed_n, 299, 301);
        apb(1'b1, VIC_OFF_CONTROL, 32'h0);
        meas(100);
        chk(lo_n, 100, 100);
    endtask : t_rate
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        meas_en = 1'b0;
        req = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_lock();
        t_duty();
        t_rate();
        finish_test();
    end
endmodule : tb_vic_interp_ctrl
`default_nettype wire

/* File: verif/vic_monitor.sv */
/* Checker for vic_interp_ctrl: bus answers, readback and output lock.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module vic_monitor
    import vic_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire vic_pkg::vic_apb_req_t apb_req,
    input wire vic_pkg::vic_apb_rsp_t apb_rsp,
    input wire logic                  oscillator_control_out
);
    logic        run_reg;
    logic [2:0]  prec_reg;
    logic [15:0] div_reg;
    logic [15:0] code_reg;
    logic        acc;
    logic        wr;
    logic        mapped;
    logic [11:0] ad;
    logic        out;
    assign acc = apb_req.psel && apb_req.penable;
    assign wr  = acc && apb_req.pwrite;
    assign ad  = apb_req.paddr;
    assign out = oscillator_control_out;
    assign mapped = ad == VIC_OFF_CONTROL || ad == VIC_OFF_INPUT
                    || ad == VIC_OFF_DIVIDER;
    // Shadow registers; the lock is judged on the old run value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg  <= 1'b0;
            prec_reg <= VIC_PREC_RESET;
            div_reg  <= VIC_DIV_RESET;
            code_reg <= VIC_CODE_RESET;
        end else if (wr) begin
            if (ad == VIC_OFF_CONTROL)
                run_reg <= apb_req.pwdata[0];
            if (ad == VIC_OFF_CONTROL && !run_reg)
                prec_reg <= apb_req.pwdata[3:1];
            if (ad == VIC_OFF_DIVIDER && !run_reg)
                div_reg <= apb_req.pwdata[15:0];
            if (ad == VIC_OFF_INPUT && run_reg)
                code_reg <= apb_req.pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(logic [11:0] o);
        acc && !apb_req.pwrite && ad == o;
    endsequence
    a_ready_always: assert property (apb_rsp.pready)
        else $error("pready low");
    a_stop_low: assert property (!run_reg |=> !out)
        else $error("output high while stopped");
    a_start_quiet: assert property ($rose(run_reg) |-> !out [*2])
        else $error("output high at start");
    a_err_unmapped: assert property (acc && !mapped |-> apb_rsp.pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (acc && mapped |-> !apb_rsp.pslverr)
        else $error("error on mapped");
    a_ctrl_read: assert property (s_rd(VIC_OFF_CONTROL) |->
        apb_rsp.prdata == {28'h0, $past(prec_reg), $past(run_reg)})
        else $error("control readback");
    a_div_read: assert property (s_rd(VIC_OFF_DIVIDER) |->
        apb_rsp.prdata == {16'h0, $past(div_reg)})
        else $error("divider readback");
    a_code_read: assert property (s_rd(VIC_OFF_INPUT) |->
        apb_rsp.prdata == {16'h0, $past(code_reg)})
        else $error("input readback");
endmodule : vic_monitor
bind vic_interp_ctrl vic_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .oscillator_control_out(oscillator_control_out));
`default_nettype wire

/* File: verif/vic_vcxo_model.sv */
/* Oscillator control input model: tallies low cycles and edges.
   Assumes the bench holds meas_en high for one window. */
`timescale 1ns/1ps
`default_nettype none
module vic_vcxo_model (
    input  wire logic   pclk,
    input  wire logic   ctrl_in,
    input  wire logic   meas_en,
    output logic [15:0] low_cnt,
    output logic [15:0] edge_cnt
);
    logic last_q;
    // Counts clear outside a window so each one starts clean
    always_ff @(posedge pclk) begin
        last_q <= ctrl_in;
        low_cnt  <= meas_en ? low_cnt + {15'h0, !ctrl_in} : 16'h0;
        edge_cnt <= meas_en ? edge_cnt + {15'h0, ctrl_in != last_q} : 16'h0;
    end
endmodule : vic_vcxo_model
`default_nettype wire
